// ===== hdl/gipm_top.sv
// Gated input power meter for one channel
`timescale 1ns/10ps
`default_nettype none
module gipm_top (
  input  wire logic                              ref_clk,
  input  wire logic                              resetn,
  input  wire logic                              smp_valid,
  input  wire logic signed [gipm_pkg::SAMPLE_W-1:0] smp_i,
  input  wire logic signed [gipm_pkg::SAMPLE_W-1:0] smp_q,
  input  wire logic                              mode_trig,
  input  wire logic [gipm_pkg::AVG_W-1:0]        avg_count,
  input  wire logic [gipm_pkg::POWER_W-1:0]      trig_level,
  output logic      [gipm_pkg::POWER_W-1:0]      result,
  output logic                                   result_valid,
  output logic                                   busy
);
  // ******************************************************
  // Sample power and neighbour windows
  // ******************************************************
  // Each sample strobe is one sample-clock tick; sample logic runs on it only
  logic [gipm_pkg::POWER_W-1:0] pwr_w;
  logic [gipm_pkg::POWER_W-1:0] tap_mid;
  logic [gipm_pkg::POWER_W-1:0] tap_w8;
  logic [gipm_pkg::POWER_W-1:0] tap_last;
  logic [gipm_pkg::WIN_SUM_W-1:0] next_sum_r;
  logic [gipm_pkg::WIN_SUM_W-1:0] prev_sum_r;
  logic [4:0] fill_r;
  wire  [gipm_pkg::POWER_W-1:0] sq_i = gipm_pkg::POWER_W'(smp_i * smp_i);
  wire  [gipm_pkg::POWER_W-1:0] sq_q = gipm_pkg::POWER_W'(smp_q * smp_q);
  // Sum cannot wrap, even at full scale on both rails; no extra width needed
  assign pwr_w = sq_i + sq_q;

  gipm_delay_line u_dly (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .shift_en (smp_valid),
    .pwr_in   (pwr_w),
    .tap_mid  (tap_mid),
    .tap_w8   (tap_w8),
    .tap_last (tap_last)
  );

  // Running sums: next window is taps 0..7, previous is taps 9..16
  wire [gipm_pkg::WIN_SUM_W-1:0] next_sum_nxt = next_sum_r + gipm_pkg::WIN_SUM_W'(pwr_w)
                                               - gipm_pkg::WIN_SUM_W'(tap_w8);
  wire [gipm_pkg::WIN_SUM_W-1:0] prev_sum_nxt = prev_sum_r + gipm_pkg::WIN_SUM_W'(tap_mid)
                                               - gipm_pkg::WIN_SUM_W'(tap_last);
  wire [gipm_pkg::WIN_SUM_W-1:0] lvl_sum = {trig_level, 3'h0};
  wire windows_full = (fill_r == 5'(gipm_pkg::DLY_LEN));
  // Mean above level equals sum above eight times level; no divider needed
  wire gate_open = windows_full && (next_sum_r > lvl_sum) && (prev_sum_r > lvl_sum);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      next_sum_r <= '0;
      prev_sum_r <= '0;
      fill_r     <= '0;
    end else if (smp_valid) begin
      next_sum_r <= next_sum_nxt;
      prev_sum_r <= prev_sum_nxt;
      fill_r     <= windows_full ? fill_r : fill_r + 5'h01;
    end
  end

  // ******************************************************
  // Accumulation
  // ******************************************************
  // Continuous mode uses the newest sample; triggered uses the centre tap
  wire mode_is_trig = (mode_trig == gipm_pkg::MODE_TRIG);
  wire take = smp_valid && (!mode_is_trig || gate_open);
  wire [gipm_pkg::POWER_W-1:0] add_pwr = mode_is_trig ? tap_mid : pwr_w;
  wire [gipm_pkg::AVG_W-1:0] avg_eff = (avg_count == '0) ? gipm_pkg::AVG_W'(1) : avg_count;
  wire [gipm_pkg::CNT_W-1:0] target = mode_is_trig ? gipm_pkg::CNT_W'(avg_eff)
                                    : gipm_pkg::CNT_W'({avg_eff, 4'h0});

  gipm_pkg::gipm_state_t state_r;
  logic [gipm_pkg::ACC_W-1:0] acc_r;
  logic [gipm_pkg::CNT_W-1:0] cnt_r;
  logic [gipm_pkg::ACC_W-1:0] rem_r;
  logic [gipm_pkg::POWER_W-1:0] quo_r;
  logic [gipm_pkg::CNT_W-1:0] div_cnt_r;
  logic [gipm_pkg::CNT_W-1:0] div_den_r;
  logic mode_prev_r;

  wire [gipm_pkg::CNT_W-1:0] cnt_inc = cnt_r + gipm_pkg::CNT_W'(1);
  wire last_take = take && (cnt_inc >= target);
  wire mode_change = (mode_trig != mode_prev_r);

  // Restoring divider, one quotient bit per cycle; acc stays cleared and samples are dropped meanwhile
  wire [gipm_pkg::ACC_W:0] rem_sh = {rem_r, 1'b0};
  wire [gipm_pkg::ACC_W:0] den_sh = {{(gipm_pkg::ACC_W-gipm_pkg::CNT_W+1-gipm_pkg::POWER_W){1'b0}},
                                     div_den_r, {gipm_pkg::POWER_W{1'b0}}};
  wire rem_ge = rem_sh >= den_sh;
  wire [gipm_pkg::ACC_W:0] rem_sub = rem_ge ? rem_sh - den_sh : rem_sh;

  assign busy = (state_r == gipm_pkg::GIPM_DIV);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r      <= gipm_pkg::GIPM_IDLE;
      acc_r        <= '0;
      cnt_r        <= '0;
      rem_r        <= '0;
      quo_r        <= '0;
      div_cnt_r    <= '0;
      div_den_r    <= '0;
      result       <= '0;
      result_valid <= 1'b0;
      mode_prev_r  <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      mode_prev_r  <= mode_trig;
      case (state_r)
        gipm_pkg::GIPM_IDLE: begin
          acc_r   <= '0;
          cnt_r   <= '0;
          state_r <= gipm_pkg::GIPM_ACC;
        end
        gipm_pkg::GIPM_ACC: begin
          if (mode_change) begin
            acc_r <= '0;
            cnt_r <= '0;
          end else if (last_take) begin
            // Result computed from sum and count, then a fresh block starts
            rem_r     <= acc_r + gipm_pkg::ACC_W'(add_pwr);
            div_den_r <= cnt_inc;
            div_cnt_r <= '0;
            quo_r     <= '0;
            acc_r     <= '0;
            cnt_r     <= '0;
            state_r   <= gipm_pkg::GIPM_DIV;
          end else if (take) begin
            acc_r <= acc_r + gipm_pkg::ACC_W'(add_pwr);
            cnt_r <= cnt_inc;
          end
        end
        gipm_pkg::GIPM_DIV: begin
          // Samples arriving here are skipped; the division is short
          rem_r     <= rem_sub[gipm_pkg::ACC_W-1:0];
          quo_r     <= {quo_r[gipm_pkg::POWER_W-2:0], rem_ge};
          div_cnt_r <= div_cnt_r + gipm_pkg::CNT_W'(1);
          if (div_cnt_r == gipm_pkg::CNT_W'(gipm_pkg::POWER_W-1)) begin
            result       <= {quo_r[gipm_pkg::POWER_W-2:0], rem_ge};
            result_valid <= 1'b1;
            state_r      <= gipm_pkg::GIPM_ACC;
          end
        end
        default: state_r <= gipm_pkg::GIPM_IDLE;
      endcase
    end
  end

  // ******************************************************
  // Checks
  // ******************************************************
  chk_cont_takes_all: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == gipm_pkg::GIPM_ACC && smp_valid && !mode_trig && !mode_change && !last_take)
    |=> (cnt_r == $past(cnt_r) + gipm_pkg::CNT_W'(1) && acc_r == $past(acc_r) + gipm_pkg::ACC_W'($past(pwr_w))))
    else $error("continuous sample not accumulated");
  chk_gate_requires_level: assert property (@(posedge ref_clk) disable iff (!resetn)
    (take && mode_trig) |-> (next_sum_r > lvl_sum && prev_sum_r > lvl_sum))
    else $error("triggered sample taken below level");
  chk_result_after_div: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(busy) |-> ##32 (result_valid && !busy))
    else $error("result not produced 32 cycles after division start");
  chk_cont_count_block: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == gipm_pkg::GIPM_ACC && !mode_trig && !mode_change && last_take) |-> (cnt_inc == {avg_eff, 4'h0}))
    else $error("continuous block length wrong");
  chk_trig_count: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == gipm_pkg::GIPM_ACC && mode_trig && !mode_change && last_take) |-> (cnt_inc == avg_eff))
    else $error("triggered count wrong");
  chk_restart_acc: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(busy) |-> (acc_r == '0 && cnt_r == '0))
    else $error("accumulator not restarted");
  chk_no_gate_unfilled: assert property (@(posedge ref_clk) disable iff (!resetn)
    !windows_full |-> !gate_open)
    else $error("gate open before windows filled");
  chk_count_on_take: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == gipm_pkg::GIPM_ACC && !smp_valid && !mode_change) |=> $stable(cnt_r))
    else $error("count moved without sample");

  // ******************************************************
  // Check helpers
  // ******************************************************
  // Dividend kept for the quotient check only; the divider itself consumes rem_r
  logic [gipm_pkg::ACC_W-1:0] num_hold_r;
  wire  [gipm_pkg::ACC_W:0]   quo_lo = (gipm_pkg::ACC_W+1)'(result) * (gipm_pkg::ACC_W+1)'(div_den_r);
  wire  [gipm_pkg::ACC_W:0]   quo_hi = quo_lo + (gipm_pkg::ACC_W+1)'(div_den_r);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      num_hold_r <= '0;
    end else if (state_r == gipm_pkg::GIPM_ACC && !mode_change && last_take) begin
      num_hold_r <= acc_r + gipm_pkg::ACC_W'(add_pwr);
    end
  end

  chk_div_quotient: assert property (@(posedge ref_clk) disable iff (!resetn)
    result_valid |-> (quo_lo <= {1'b0, num_hold_r} && quo_hi > {1'b0, num_hold_r}))
    else $error("result is not the truncated mean");
  chk_valid_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
    result_valid |=> !result_valid)
    else $error("result valid longer than one cycle");
  chk_trig_includes: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == gipm_pkg::GIPM_ACC && mode_trig && !mode_change && smp_valid && windows_full && !last_take
     && next_sum_r > lvl_sum && prev_sum_r > lvl_sum)
    |=> (cnt_r == $past(cnt_r) + gipm_pkg::CNT_W'(1) && acc_r == $past(acc_r) + gipm_pkg::ACC_W'($past(tap_mid))))
    else $error("triggered sample above level not included");
  chk_trig_skips: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_r == gipm_pkg::GIPM_ACC && mode_trig && !mode_change && smp_valid
     && !(windows_full && next_sum_r > lvl_sum && prev_sum_r > lvl_sum))
    |=> ($stable(cnt_r) && $stable(acc_r)))
    else $error("excluded sample moved the count");
endmodule : gipm_top
`default_nettype wire

// ===== hdl/gipm_pkg.sv
// Package of constants for the gated input power meter
package gipm_pkg;
  localparam int SAMPLE_W      = 16;
  localparam int POWER_W       = 32;
  localparam int ACC_W         = 56;
  localparam int AVG_W         = 16;
  localparam int CNT_W         = 24;
  localparam int BLOCK_LEN     = 16;
  localparam int BLOCK_SHIFT   = 4;
  localparam int WIN_LEN       = 8;
  localparam int WIN_SHIFT     = 3;
  localparam int WIN_SUM_W     = 35;
  localparam int DLY_LEN       = 17;
  localparam int SAMPLE_MHZ    = 78;
  localparam int REF_MHZ       = 20;
  localparam int DIV_LEN       = 1;
  localparam logic MODE_CONT   = 1'b0;
  localparam logic MODE_TRIG   = 1'b1;
  typedef enum logic [1:0] {GIPM_IDLE, GIPM_ACC, GIPM_DIV} gipm_state_t;
endpackage : gipm_pkg

// ===== hdl/gipm_delay_line.sv
// Sample power delay line of seventeen taps, registered outputs
`timescale 1ns/10ps
`default_nettype none
module gipm_delay_line (
  input  wire logic                              ref_clk,
  input  wire logic                              resetn,
  input  wire logic                              shift_en,
  input  wire logic [gipm_pkg::POWER_W-1:0]      pwr_in,
  output logic      [gipm_pkg::POWER_W-1:0]      tap_mid,
  output logic      [gipm_pkg::POWER_W-1:0]      tap_w8,
  output logic      [gipm_pkg::POWER_W-1:0]      tap_last
);
  logic [gipm_pkg::POWER_W-1:0] mem_r [gipm_pkg::DLY_LEN];
  genvar g;
  generate
    for (g = 0; g < gipm_pkg::DLY_LEN; g++) begin : g_tap
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          mem_r[g] <= '0;
        end else if (shift_en) begin
          mem_r[g] <= (g == 0) ? pwr_in : mem_r[(g == 0) ? 0 : g-1];
        end
      end
    end
  endgenerate
  // mem_r[0] newest; mem_r[8] the centre sample once shifted
  assign tap_mid  = mem_r[gipm_pkg::WIN_LEN];
  assign tap_w8   = mem_r[gipm_pkg::WIN_LEN-1];
  assign tap_last = mem_r[gipm_pkg::DLY_LEN-1];
endmodule : gipm_delay_line
`default_nettype wire

// ===== testbench/gipm_src_model.sv
// Sample stream source standing in for the channel input
`timescale 1ns/10ps
`default_nettype none
module gipm_src_model (
  input  wire logic                                 ref_clk,
  output var  logic                                 smp_valid,
  output var  logic signed [gipm_pkg::SAMPLE_W-1:0] smp_i,
  output var  logic signed [gipm_pkg::SAMPLE_W-1:0] smp_q
);
  initial begin
    smp_valid = 1'b0;
    smp_i     = '0;
    smp_q     = '0;
  end
  // Ramp of n back-to-back samples; released lines show inverted data, never a stale sample
  task automatic send(input int n, input int i0, input int step, input int q);
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk);
      smp_valid <= 1'b1;
      smp_i     <= 16'(i0 + k * step);
      smp_q     <= 16'(q);
    end
    @(posedge ref_clk);
    smp_valid <= 1'b0;
    smp_i     <= ~smp_i;
    smp_q     <= ~smp_q;
  endtask : send
endmodule : gipm_src_model
`default_nettype wire

// ===== testbench/gipm_top_tb.sv
// Self-checking bench for the gated input power meter
`timescale 1ns/10ps
`default_nettype none
module gipm_top_tb;
  logic                                 ref_clk, resetn, smp_valid, mode_trig, result_valid, busy;
  logic signed [gipm_pkg::SAMPLE_W-1:0] smp_i, smp_q;
  logic        [gipm_pkg::AVG_W-1:0]    avg_count;
  logic        [gipm_pkg::POWER_W-1:0]  trig_level, result, last_res;
  int                                   err_total, checked, cyc, res_cyc, n_res, t0;

  gipm_src_model i_gipm_src_model (.ref_clk(ref_clk), .smp_valid(smp_valid), .smp_i(smp_i), .smp_q(smp_q));
  gipm_top i_gipm_top (.ref_clk(ref_clk), .resetn(resetn), .smp_valid(smp_valid), .smp_i(smp_i),
    .smp_q(smp_q), .mode_trig(mode_trig), .avg_count(avg_count), .trig_level(trig_level),
    .result(result), .result_valid(result_valid), .busy(busy));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Result monitor; cycle stamp taken after the count moves on
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (result_valid === 1'b1) begin
      n_res    = n_res + 1;
      res_cyc  = cyc;
      last_res = result;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wait_res(input int target);
    for (int k = 0; k < 2000 && n_res < target; k++) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : wait_res

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // ****************************************
  // Scenarios
  // ****************************************
  // One block of sixteen ramp samples: sum 1496, floor mean 93, answer 33 edges on
  task automatic cont_one();
    int n0;
    n0 = n_res;
    i_gipm_src_model.send(16, 1, 1, 0);
    @(negedge ref_clk);
    t0 = cyc;
    check("busy", busy, 1);
    wait_res(n0 + 1);
    check("cont1 result", last_res, 32'h0000005D);
    check("latency", res_cyc - t0, 33);
  endtask : cont_one

  // Two blocks with a nonzero q: sum 11568 over 32, exactly one result
  task automatic cont_two();
    int n0;
    n0 = n_res;
    @(posedge ref_clk);
    avg_count <= 16'h0002;
    i_gipm_src_model.send(32, 1, 1, 2);
    wait_res(n0 + 1);
    repeat (40) @(posedge ref_clk);
    check("cont2 result", last_res, 32'h00000169);
    check("cont2 count", n_res - n0, 1);
  endtask : cont_two

  // Zeros go in while still continuous, so ramp power left in the windows is never included.
  // Short spike is gated out; four samples from the first long burst, two from the second
  task automatic trig_bursts();
    int n0;
    n0 = n_res;
    i_gipm_src_model.send(20, 0, 0, 0);
    @(posedge ref_clk);
    mode_trig  <= 1'b1;
    trig_level <= 32'h00000186;
    avg_count  <= 16'h0006;
    i_gipm_src_model.send(12, 20, 0, 0);
    i_gipm_src_model.send(20, 0, 0, 0);
    i_gipm_src_model.send(20, 20, 0, 0);
    i_gipm_src_model.send(20, 0, 0, 0);
    i_gipm_src_model.send(20, 21, 0, 0);
    i_gipm_src_model.send(30, 0, 0, 0);
    wait_res(n0 + 1);
    repeat (40) @(posedge ref_clk);
    check("trig result", last_res, 32'h0000019D);
    check("trig count", n_res - n0, 1);
  endtask : trig_bursts

  initial begin
    resetn     = 1'b0;
    mode_trig  = 1'b0;
    avg_count  = 16'h0001;
    trig_level = '0;
    err_total  = 0;
    checked    = 0;
    cyc        = 0;
    n_res      = 0;
    res_cyc    = 0;
    last_res   = '0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    check("reset valid", result_valid, 0);
    check("reset busy", busy, 0);
    check("reset result", result, 0);
    repeat (3) @(posedge ref_clk);
    cont_one();
    cont_two();
    trig_bursts();
    give_verdict();
  end

  // Tests need well under 1000 cycles; a hang ends the run as a failure
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
endmodule : gipm_top_tb
`default_nettype wire
